// >>> include/sros_pkg.sv
`default_nettype none

package sros_pkg;

   // ------------------------------------------------------------
   // Commands presented on the command port
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      CMD_OPC    = 4'h0,
      CMD_OPC_Q  = 4'h1,
      CMD_WAI    = 4'h2,
      CMD_RST    = 4'h3,
      CMD_CLS    = 4'h4,
      CMD_MSK_WR = 4'h5,
      CMD_MSK_RD = 4'h6,
      CMD_SBY_RD = 4'h7,
      CMD_ESE_WR = 4'h8,
      CMD_ESE_RD = 4'h9,
      CMD_ESR_RD = 4'ha,
      CMD_TST    = 4'hb,
      CMD_LMC    = 4'hc
   } sros_cmd_e;

   // ------------------------------------------------------------
   // Status byte and event register layout
   // ------------------------------------------------------------
   localparam int unsigned SBY_QSB = 3;
   localparam int unsigned SBY_MAV = 4;
   localparam int unsigned SBY_ESB = 5;
   localparam int unsigned SBY_MSS = 6;
   localparam int unsigned SBY_OSB = 7;
   localparam int unsigned ESR_OPC = 0;

   localparam logic [7:0] MSK_WMASK = 8'hb8;
   localparam logic [7:0] MSS_EXCL  = 8'hbf;
   localparam logic [7:0] MSK_RST   = 8'h00;
   localparam logic [7:0] ESE_RST   = 8'h00;
   localparam logic [7:0] ESR_RST   = 8'h00;

   // ------------------------------------------------------------
   // Response codes
   // ------------------------------------------------------------
   localparam logic [7:0]  ASCII_ONE    = 8'h31;
   localparam logic [7:0]  ASCII_QUOTE  = 8'h22;
   localparam logic [7:0]  TST_NOFINISH = 8'hff;
   localparam logic [7:0]  TST_FAILDEF  = 8'h01;
   localparam logic [15:0] ERR_SELFTEST = 16'hfeb6;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned ST_TIMEOUT_MS  = 100;
   localparam int unsigned ST_TIMEOUT_CYC = (ST_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned ST_CNT_W       = 24;

endpackage

`default_nettype wire

// >>> verilog/sros_meas_edge.sv
`default_nettype none

module sros_meas_edge (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic measActive,
   output logic      idleEvent
);

   logic syncA;
   logic syncB;
   logic prevB;
   logic next_syncA;
   logic next_syncB;
   logic next_prevB;

   // ------------------------------------------------------------
   // Synchroniser and falling edge
   // ------------------------------------------------------------
   always_comb begin
      next_syncA = measActive;
      next_syncB = syncA;
      next_prevB = syncB;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         syncA <= 1'b0;
         syncB <= 1'b0;
         prevB <= 1'b0;
      end else begin
         syncA <= next_syncA;
         syncB <= next_syncB;
         prevB <= next_prevB;
      end
   end

   assign idleEvent = prevB & ~syncB;

endmodule // sros_meas_edge

`default_nettype wire

// >>> verilog/sros_status_core.sv
`default_nettype none

module sros_status_core #(
   parameter int unsigned TEST_TIMEOUT_CYC = sros_pkg::ST_TIMEOUT_CYC
) (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic                cmdValid,
   input  wire sros_pkg::sros_cmd_e cmdCode,
   input  wire logic [7:0]          cmdData,
   output logic                     cmdReady,
   output logic                     respValid,
   output logic [7:0]               respData,
   input  wire logic                devClear,
   input  wire logic                measActive,
   input  wire logic [7:0]          esrEvents,
   input  wire logic                queueSummary,
   input  wire logic                msgAvailable,
   input  wire logic                operSummary,
   input  wire logic                spollReq,
   output logic [7:0]               spollByte,
   output logic                     srqOut,
   output logic                     rqsFlag,
   output logic                     macroEnable,
   output logic                     settingsReset,
   output logic                     macroListReq,
   input  wire logic                macroDefined,
   output logic                     selfTestStart,
   input  wire logic                selfTestDone,
   input  wire logic                selfTestPass,
   input  wire logic [7:0]          selfTestCode,
   output logic                     errorEvent,
   output logic [15:0]              errorCode
);

   localparam int unsigned CW = sros_pkg::ST_CNT_W;
   localparam logic [CW-1:0] TO_LAST = CW'(TEST_TIMEOUT_CYC - 1);

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_WAIT = 3'h1,
      S_OPCQ = 3'h2,
      S_TEST = 3'h3,
      S_LMC2 = 3'h4
   } sros_state_e;

   sros_state_e   state;
   sros_state_e   next_state;
   logic [7:0]    reqMask;
   logic [7:0]    next_reqMask;
   logic [7:0]    ese;
   logic [7:0]    next_ese;
   logic [7:0]    esr;
   logic [7:0]    next_esr;
   logic          opcArmed;
   logic          next_opcArmed;
   logic          rqs;
   logic          next_rqs;
   logic          prevMss;
   logic [CW-1:0] testCnt;
   logic [CW-1:0] next_testCnt;
   logic          next_respValid;
   logic [7:0]    next_respData;
   logic [7:0]    next_spollByte;
   logic          next_macroEnable;
   logic          next_settingsReset;
   logic          next_macroListReq;
   logic          next_selfTestStart;
   logic          next_errorEvent;
   logic          idleEvent;
   logic          accept;
   logic          mss;
   logic [7:0]    statByte;
   logic [7:0]    esrSet;
   logic [7:0]    esrClr;

   sros_meas_edge u_edge (
      .clk        (clk),
      .reset      (reset),
      .measActive (measActive),
      .idleEvent  (idleEvent)
   );

   // ------------------------------------------------------------
   // Status byte and summary
   // ------------------------------------------------------------
   always_comb begin
      statByte = 8'h00;
      statByte[sros_pkg::SBY_QSB] = queueSummary;
      statByte[sros_pkg::SBY_MAV] = msgAvailable;
      statByte[sros_pkg::SBY_ESB] = |(esr & ese);
      statByte[sros_pkg::SBY_OSB] = operSummary;
   end

   assign mss      = |(statByte & reqMask & sros_pkg::MSS_EXCL);
   assign srqOut   = mss;
   assign rqsFlag  = rqs;
   assign cmdReady = (state == S_IDLE);
   assign accept   = cmdValid && cmdReady;
   assign errorCode = sros_pkg::ERR_SELFTEST;

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      next_state         = state;
      next_reqMask       = reqMask;
      next_ese           = ese;
      next_testCnt       = testCnt;
      next_respValid     = 1'b0;
      next_respData      = respData;
      next_macroEnable   = macroEnable;
      next_settingsReset = 1'b0;
      next_macroListReq  = 1'b0;
      next_selfTestStart = 1'b0;
      next_errorEvent    = 1'b0;
      next_spollByte     = spollByte;
      esrSet             = esrEvents;
      esrClr             = 8'h00;
      next_opcArmed      = opcArmed;

      // Event set beats a same-cycle clear so nothing is lost
      esrSet[sros_pkg::ESR_OPC] = esrEvents[sros_pkg::ESR_OPC] | (opcArmed & idleEvent);
      if (idleEvent || devClear) begin
         next_opcArmed = 1'b0;
      end

      // Request flag rises with the summary and drops once polled
      next_rqs = (rqs & ~spollReq) | (mss & ~prevMss);
      if (spollReq) begin
         next_spollByte = statByte | {1'b0, rqs, 6'h00};
      end

      unique case (state)
         S_IDLE: begin
            if (accept) begin
               unique case (cmdCode)
                  sros_pkg::CMD_OPC: begin
                     next_opcArmed = 1'b1;
                  end
                  sros_pkg::CMD_OPC_Q: begin
                     next_state = S_OPCQ;
                  end
                  sros_pkg::CMD_WAI: begin
                     next_state = S_WAIT;
                  end
                  sros_pkg::CMD_RST: begin
                     // Masks, event register and queue are left alone
                     next_opcArmed      = 1'b0;
                     next_macroEnable   = 1'b0;
                     next_settingsReset = 1'b1;
                  end
                  sros_pkg::CMD_CLS: begin
                     next_opcArmed = 1'b0;
                     esrClr        = 8'hff;
                  end
                  sros_pkg::CMD_MSK_WR: begin
                     next_reqMask = cmdData & sros_pkg::MSK_WMASK;
                  end
                  sros_pkg::CMD_MSK_RD: begin
                     next_respValid = 1'b1;
                     next_respData  = reqMask;
                  end
                  sros_pkg::CMD_SBY_RD: begin
                     // Pure read: no side effect on status or request state
                     next_respValid = 1'b1;
                     next_respData  = statByte | {1'b0, mss, 6'h00};
                  end
                  sros_pkg::CMD_ESE_WR: begin
                     next_ese = cmdData;
                  end
                  sros_pkg::CMD_ESE_RD: begin
                     next_respValid = 1'b1;
                     next_respData  = ese;
                  end
                  sros_pkg::CMD_ESR_RD: begin
                     next_respValid = 1'b1;
                     next_respData  = esr;
                     esrClr         = 8'hff;
                  end
                  sros_pkg::CMD_TST: begin
                     next_selfTestStart = 1'b1;
                     next_testCnt       = '0;
                     next_state         = S_TEST;
                  end
                  sros_pkg::CMD_LMC: begin
                     if (macroDefined) begin
                        next_macroListReq = 1'b1;
                     end else begin
                        next_respValid = 1'b1;
                        next_respData  = sros_pkg::ASCII_QUOTE;
                        next_state     = S_LMC2;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         S_WAIT: begin
            if (idleEvent || devClear) begin
               next_state = S_IDLE;
            end
         end
         S_OPCQ: begin
            if (devClear) begin
               next_state = S_IDLE;
            end else if (idleEvent) begin
               next_respValid = 1'b1;
               next_respData  = sros_pkg::ASCII_ONE;
               next_state     = S_IDLE;
            end
         end
         S_TEST: begin
            next_testCnt = testCnt + 1'b1;
            if (selfTestDone) begin
               next_respValid  = 1'b1;
               next_errorEvent = ~selfTestPass;
               next_state      = S_IDLE;
               if (selfTestPass) begin
                  next_respData = 8'h00;
               end else if (selfTestCode == 8'h00) begin
                  next_respData = sros_pkg::TST_FAILDEF;
               end else begin
                  next_respData = selfTestCode;
               end
            end else if (testCnt == TO_LAST) begin
               // A hung test still answers, flagged as not finished
               next_respValid  = 1'b1;
               next_respData   = sros_pkg::TST_NOFINISH;
               next_errorEvent = 1'b1;
               next_state      = S_IDLE;
            end
         end
         S_LMC2: begin
            next_respValid = 1'b1;
            next_respData  = sros_pkg::ASCII_QUOTE;
            next_state     = S_IDLE;
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase

      next_esr = (esr & ~esrClr) | esrSet;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         state         <= S_IDLE;
         reqMask       <= sros_pkg::MSK_RST;
         ese           <= sros_pkg::ESE_RST;
         esr           <= sros_pkg::ESR_RST;
         opcArmed      <= 1'b0;
         rqs           <= 1'b0;
         prevMss       <= 1'b0;
         testCnt       <= '0;
         respValid     <= 1'b0;
         respData      <= 8'h00;
         spollByte     <= 8'h00;
         macroEnable   <= 1'b1;
         settingsReset <= 1'b0;
         macroListReq  <= 1'b0;
         selfTestStart <= 1'b0;
         errorEvent    <= 1'b0;
      end else begin
         state         <= next_state;
         reqMask       <= next_reqMask;
         ese           <= next_ese;
         esr           <= next_esr;
         opcArmed      <= next_opcArmed;
         rqs           <= next_rqs;
         prevMss       <= mss;
         testCnt       <= next_testCnt;
         respValid     <= next_respValid;
         respData      <= next_respData;
         spollByte     <= next_spollByte;
         macroEnable   <= next_macroEnable;
         settingsReset <= next_settingsReset;
         macroListReq  <= next_macroListReq;
         selfTestStart <= next_selfTestStart;
         errorEvent    <= next_errorEvent;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence sOpcqWaiting;
      state == S_OPCQ && !devClear;
   endsequence

   sequence sOpcqAnswer;
      respValid && respData == 8'h31 && state == S_IDLE;
   endsequence

   // A fresh arm in the same cycle as the idle edge keeps the event armed
   AST_OPC_SETS_BIT: assert property (opcArmed && idleEvent && !(accept && cmdCode == sros_pkg::CMD_OPC)
                                      |=> esr[0] && !opcArmed)
      else $error("armed completion did not set event bit 0");
   AST_OPC_CLS_DISARM: assert property (accept && cmdCode == sros_pkg::CMD_CLS |=> !opcArmed)
      else $error("clear left completion armed");
   AST_OPCQ_ANSWER: assert property (sOpcqWaiting ##0 idleEvent |=> sOpcqAnswer)
      else $error("completion query did not answer one at idle edge");
   AST_OPCQ_HOLD: assert property (sOpcqWaiting ##0 !idleEvent |=> state == S_OPCQ && !respValid)
      else $error("completion query left holdoff early");
   AST_RST_KEEPS: assert property (accept && cmdCode == sros_pkg::CMD_RST
                                   |=> reqMask == $past(reqMask) && ese == $past(ese) && !macroEnable)
      else $error("reset command disturbed masks or left macros on");
   // Built bit by bit from the sources so a wrong byte layout is caught too
   AST_SRQ_SUMMARY: assert property (srqOut == ((queueSummary && reqMask[3]) || (msgAvailable && reqMask[4])
                                     || ((|(esr & ese)) && reqMask[5]) || (operSummary && reqMask[7])))
      else $error("service request not equal to masked summary");
   AST_MASK_READ: assert property (accept && cmdCode == sros_pkg::CMD_MSK_RD
                                   |=> respValid && respData[6] == 1'b0 && respData[2:0] == 3'h0)
      else $error("mask read shows bit 6 or unused bits");
   AST_SBYTE_READ: assert property (accept && cmdCode == sros_pkg::CMD_SBY_RD
                                    |=> respValid && respData[6] == $past(mss) && respData[2:0] == 3'h0)
      else $error("status byte read malformed");
   AST_POLL_RQS: assert property (spollReq |=> spollByte[6] == $past(rqs))
      else $error("serial poll bit 6 is not the request flag");
   AST_WAI_STALL: assert property (state == S_WAIT && !idleEvent && !devClear |=> !cmdReady)
      else $error("wait holdoff released without idle edge");
   AST_TST_ERROR: assert property (state == S_TEST && selfTestDone && !selfTestPass
                                   |=> errorEvent && respValid && respData != 8'h00)
      else $error("failed self-test not reported");
   AST_ESR_READ_CLR: assert property (accept && cmdCode == sros_pkg::CMD_ESR_RD && esrEvents == 8'h00
                                      && !(opcArmed && idleEvent) |=> esr == 8'h00)
      else $error("event register not cleared by read");

endmodule // sros_status_core

`default_nettype wire

// >>> dv/sros_ctrl_model.sv
`default_nettype none

module sros_ctrl_model (
   input  wire logic          clk,
   input  wire logic          cmdReady,
   output var sros_pkg::sros_cmd_e cmdCode,
   output logic               cmdValid,
   output logic [7:0]         cmdData,
   output logic               spollReq
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cmdValid = 1'b0;
      cmdCode  = sros_pkg::CMD_SBY_RD;
      cmdData  = 8'h00;
      spollReq = 1'b0;
   end

   // ------------------------------------------------------------
   // Command and poll requests
   // ------------------------------------------------------------
   // A random idle gap of 1 to 3 cycles gives both prompt and slow
   // requests, and keeps two NBAs on cmdValid out of one time step
   task automatic issue(input sros_pkg::sros_cmd_e c, input logic [7:0] d);
      repeat (1 + $urandom_range(2)) @(posedge clk);
      cmdValid <= 1'b1;
      cmdCode  <= c;
      cmdData  <= d;
      do @(posedge clk); while (cmdReady !== 1'b1);
      cmdValid <= 1'b0;
      // Released data must not look like a held value
      cmdData  <= ~d;
   endtask

   task automatic poll();
      spollReq <= 1'b1;
      @(posedge clk);
      spollReq <= 1'b0;
   endtask
endmodule // sros_ctrl_model

`default_nettype wire

// >>> dv/status_reporting_opc_sync_test.sv
`default_nettype none

module status_reporting_opc_sync_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic                clk = 1'b0, reset = 1'b1, devClear = 1'b0, measActive = 1'b0, macroDefined = 1'b0;
   logic                queueSummary = 1'b0, msgAvailable = 1'b0, operSummary = 1'b0;
   logic                selfTestDone = 1'b0, selfTestPass = 1'b0;
   logic [7:0]          esrEvents = 8'h00, selfTestCode = 8'h00;
   logic                cmdValid, cmdReady, respValid, spollReq, srqOut, rqsFlag, macroEnable;
   logic                errorEvent, macroListReq, settingsReset, selfTestStart;
   logic [7:0]          cmdData, respData, spollByte, reqMask, d, e;
   logic [15:0]         errorCode;
   sros_pkg::sros_cmd_e cmdCode;
   int                  nErrors = 0, numChecks = 0, nErrEv = 0, nListReq = 0, nSetRst = 0, nTstStart = 0;

   initial begin
      forever #5 clk = ~clk;
   end

   sros_status_core #(.TEST_TIMEOUT_CYC(20)) sros_status_core_inst (
      .clk(clk), .reset(reset), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData),
      .cmdReady(cmdReady), .respValid(respValid), .respData(respData), .devClear(devClear),
      .measActive(measActive), .esrEvents(esrEvents), .queueSummary(queueSummary),
      .msgAvailable(msgAvailable), .operSummary(operSummary), .spollReq(spollReq),
      .spollByte(spollByte), .srqOut(srqOut), .rqsFlag(rqsFlag), .macroEnable(macroEnable),
      .settingsReset(settingsReset), .macroListReq(macroListReq), .macroDefined(macroDefined),
      .selfTestStart(selfTestStart), .selfTestDone(selfTestDone), .selfTestPass(selfTestPass),
      .selfTestCode(selfTestCode), .errorEvent(errorEvent), .errorCode(errorCode));

   sros_ctrl_model sros_ctrl_model_inst (
      .clk(clk), .cmdReady(cmdReady), .cmdCode(cmdCode), .cmdValid(cmdValid),
      .cmdData(cmdData), .spollReq(spollReq));

   always @(posedge clk) begin
      nErrEv   <= nErrEv + int'(errorEvent === 1'b1);
      nListReq <= nListReq + int'(macroListReq === 1'b1);
      nSetRst  <= nSetRst + int'(settingsReset === 1'b1);
      nTstStart <= nTstStart + int'(selfTestStart === 1'b1);
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic getResp(output logic [7:0] r);
      r = 8'hxx;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         if (respValid === 1'b1) begin
            r = respData;
            break;
         end
      end
   endtask

   task automatic query(input sros_pkg::sros_cmd_e c, output logic [7:0] r);
      sros_ctrl_model_inst.issue(c, 8'($urandom_range(255)));
      getResp(r);
   endtask

   // Measurement runs long enough to pass the input synchroniser
   task automatic measFall(input int post);
      measActive <= 1'b1;
      repeat (4) @(posedge clk);
      measActive <= 1'b0;
      repeat (post) @(posedge clk);
   endtask

   function automatic logic [7:0] expSbyte(input logic [7:0] m, input logic esb);
      logic [7:0] b;
      b = {operSummary, 1'b0, esb, msgAvailable, queueSummary, 3'b000};
      b[6] = |(b & m);
      return b;
   endfunction

   task automatic reportAndStop();
      $display("checks %0d errors %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (4000) @(posedge clk);
      nErrors++;
      reportAndStop();
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      void'($urandom(25399));
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      check("srq", srqOut, 16'h0000);
      check("macro", macroEnable, 16'h0001);
      check("poll", spollByte, 16'h0000);
      query(sros_pkg::CMD_SBY_RD, d);
      check("sbyte", d, 8'h00);
      for (int i = 0; i < 8; i++) begin
         reqMask = (i == 0) ? 8'hff : 8'($urandom_range(255));
         queueSummary <= 1'($urandom_range(1));
         msgAvailable <= (i == 0) ? 1'b1 : 1'($urandom_range(1));
         operSummary  <= 1'($urandom_range(1));
         sros_ctrl_model_inst.issue(sros_pkg::CMD_MSK_WR, reqMask);
         query(sros_pkg::CMD_MSK_RD, d);
         check("mask", d, reqMask & 8'hb8);
         e = expSbyte(reqMask & 8'hb8, 1'b0);
         check("srq", srqOut, e[6]);
         repeat (2) begin
            query(sros_pkg::CMD_SBY_RD, d);
            check("sbyte", d, e);
         end
      end
      queueSummary <= 1'b0;
      msgAvailable <= 1'b0;
      operSummary  <= 1'b0;
      sros_ctrl_model_inst.issue(sros_pkg::CMD_MSK_WR, 8'h10);
      sros_ctrl_model_inst.poll();
      msgAvailable <= 1'b1;
      repeat (2) @(posedge clk);
      check("rqs", rqsFlag, 16'h0001);
      sros_ctrl_model_inst.poll();
      @(posedge clk);
      check("poll", spollByte, 8'h50);
      sros_ctrl_model_inst.poll();
      @(posedge clk);
      check("poll", spollByte, 8'h10);
      msgAvailable <= 1'b0;
      sros_ctrl_model_inst.issue(sros_pkg::CMD_ESE_WR, 8'h01);
      sros_ctrl_model_inst.issue(sros_pkg::CMD_OPC, 8'h00);
      measFall(5);
      query(sros_pkg::CMD_SBY_RD, d);
      check("sbyte", d, 8'h20);
      query(sros_pkg::CMD_ESR_RD, d);
      check("esr", d, 8'h01);
      query(sros_pkg::CMD_ESR_RD, d);
      check("esr", d, 8'h00);
      // Clear-status and reset both drop an armed completion event
      for (int j = 0; j < 2; j++) begin
         sros_ctrl_model_inst.issue(sros_pkg::CMD_OPC, 8'h00);
         sros_ctrl_model_inst.issue(sros_pkg::sros_cmd_e'((j == 0) ? sros_pkg::CMD_CLS : sros_pkg::CMD_RST), 8'h00);
         measFall(5);
         query(sros_pkg::CMD_ESR_RD, d);
         check("esr", d, 8'h00);
      end
      check("macro", macroEnable, 16'h0000);
      check("settings reset", nSetRst, 16'h0001);
      query(sros_pkg::CMD_MSK_RD, d);
      check("mask", d, 8'h10);
      sros_ctrl_model_inst.issue(sros_pkg::CMD_OPC_Q, 8'h00);
      repeat (3) @(posedge clk);
      check("ready", cmdReady, 16'h0000);
      measFall(0);
      getResp(d);
      check("opcq", d, 8'h31);
      for (int j = 0; j < 2; j++) begin
         sros_ctrl_model_inst.issue(sros_pkg::sros_cmd_e'((j == 0) ? sros_pkg::CMD_OPC_Q : sros_pkg::CMD_WAI), 8'h00);
         @(posedge clk);
         check("ready", cmdReady, 16'h0000);
         devClear <= 1'b1;
         @(posedge clk);
         devClear <= 1'b0;
         repeat (2) @(posedge clk);
         check("ready", cmdReady, 16'h0001);
      end
      sros_ctrl_model_inst.issue(sros_pkg::CMD_WAI, 8'h00);
      measFall(5);
      query(sros_pkg::CMD_MSK_RD, d);
      check("mask", d, 8'h10);
      for (int k = 0; k < 3; k++) begin
         sros_ctrl_model_inst.issue(sros_pkg::CMD_TST, 8'h00);
         repeat (3) @(posedge clk);
         e = (k == 1) ? 8'($urandom_range(255, 2)) : 8'h00;
         selfTestDone <= 1'b1;
         selfTestPass <= (k == 0);
         selfTestCode <= e;
         @(posedge clk);
         selfTestDone <= 1'b0;
         getResp(d);
         check("selftest", d, (k == 2) ? 8'h01 : e);
      end
      // The last error pulse is counted at this very edge, so let it land
      @(posedge clk);
      check("errors raised", nErrEv, 16'h0002);
      check("error code", errorCode, 16'hfeb6);
      // No completion at all must still answer, with a nonzero value
      query(sros_pkg::CMD_TST, d);
      check("selftest", d, 8'hff);
      query(sros_pkg::CMD_LMC, d);
      check("labels", d, 8'h22);
      @(posedge clk);
      check("labels", {respValid, respData}, 9'h122);
      macroDefined <= 1'b1;
      sros_ctrl_model_inst.issue(sros_pkg::CMD_LMC, 8'h00);
      repeat (3) @(posedge clk);
      check("label list", nListReq, 16'h0001);
      check("tests started", nTstStart, 16'h0004);
      check("errors raised", nErrEv, 16'h0003);
      reportAndStop();
   end
endmodule // status_reporting_opc_sync_test

`default_nettype wire
